// >>> ark_pkg.sv
package ark_pkg;
	localparam int ALG_W = 8;
	localparam int N_ALG = 256;
	localparam int ID_W = 8;
	localparam int NR_W = 4;
	localparam int SET_BIT = 3;
	localparam int SLOT_BITS = 3;
	localparam int N_BANKS = 4;
	localparam int BANK_UAK = 0;
	localparam int BANK_AC = 1;
	localparam int BANK_STATIC = 2;
	localparam int BANK_DERIVED = 3;
	localparam logic [7:0] RSN_NO_AUTH = 8'h0b;
	localparam logic [7:0] RSN_AUTH_UNSUP = 8'h0c;
	localparam logic [7:0] RSN_NO_CIPHER = 8'h11;
	localparam logic [7:0] RSN_CIPHER_UNSUP = 8'h12;
	localparam logic [3:0] AKT_USER = 4'h1;
	localparam logic [3:0] AKT_CODE = 4'h2;
	localparam logic [3:0] AKT_USER_PERSONAL = 4'h3;
	localparam logic [3:0] CKT_STATIC = 4'h1;
	localparam logic [3:0] CKT_DERIVED = 4'h2;
	localparam logic [1:0] KOP_LOOKUP = 2'h0;
	localparam logic [1:0] KOP_ENTER = 2'h1;
	localparam logic [1:0] KOP_STORE = 2'h2;
	localparam logic [1:0] KOP_ALLOC = 2'h3;

	typedef enum logic [2:0] {
		NEG_IDLE = 3'b001,
		NEG_JUDGE = 3'b010,
		NEG_ANSWER = 3'b100
	} ark_neg_e;
	localparam ark_neg_e NEG_RESET = NEG_IDLE;

	typedef struct packed {
		logic present;
		logic [ALG_W-1:0] alg_id;
		logic [3:0] key_type;
		logic [NR_W-1:0] key_nr;
		logic store_derived_key_flag;
	} ark_prop_s;

	typedef struct packed {
		logic accept;
		logic auth_rsn_valid;
		logic [7:0] auth_rsn;
		logic cipher_rsn_valid;
		logic [7:0] cipher_rsn;
		ark_prop_s auth_echo;
		ark_prop_s cipher_echo;
		logic alt_auth_valid;
		logic [ALG_W-1:0] alt_auth_id;
		logic alt_cipher_valid;
		logic [ALG_W-1:0] alt_cipher_id;
	} ark_reply_s;

	typedef struct packed {
		logic [1:0] op;
		logic cipher_sel;
		logic [3:0] key_type;
		logic [NR_W-1:0] key_nr;
		logic [NR_W-1:0] new_nr;
		logic store_derived_key_flag;
		logic [ID_W-1:0] id;
	} ark_key_cmd_s;
endpackage

// >>> ark_alg_check.sv
module ark_alg_check #(
	parameter logic [7:0] NO_CODE = ark_pkg::RSN_NO_AUTH,
	parameter logic [7:0] UNSUP_CODE = ark_pkg::RSN_AUTH_UNSUP
) (
	input wire ark_pkg::ark_prop_s prop_i, // Proposal element
	input wire logic [ark_pkg::N_ALG-1:0] supported_i, // One bit per algorithm
	output logic ok_o, // Element acceptable
	output logic reason_valid_o, // Reject reason present
	output logic [7:0] reason_o, // Reject reason code
	output logic alt_valid_o, // Alternative exists
	output logic [ark_pkg::ALG_W-1:0] alt_id_o // Most preferred alternative
);
	always_comb begin
		ok_o = prop_i.present && supported_i[prop_i.alg_id];
		reason_valid_o = !ok_o;
		reason_o = 8'h00;
		if (!prop_i.present) begin
			reason_o = NO_CODE;
		end else if (!ok_o) begin
			reason_o = UNSUP_CODE;
		end
		alt_valid_o = 1'b0;
		alt_id_o = '0;
		// Lowest index wins: it is the preferred alternative
		for (int i = ark_pkg::N_ALG - 1; i >= 0; i--) begin
			if (supported_i[i]) begin
				alt_valid_o = 1'b1;
				alt_id_o = ark_pkg::ALG_W'(i);
			end
		end
	end
endmodule

// >>> ark_key_bank.sv
module ark_key_bank #(
	parameter int N_ID = 4,
	parameter int KEY_W = 128
) (
	input wire logic clk_i, // Core clock
	input wire logic ce_i, // Freezes state when low
	input wire logic erase_i, // Invalidate every slot
	input wire logic [ark_pkg::ID_W-1:0] id_i, // Identity index
	input wire logic wr_en_i, // Write strobe
	input wire logic [ark_pkg::NR_W-1:0] wr_nr_i, // Write key number
	input wire logic [KEY_W-1:0] wr_data_i, // Key to store
	input wire logic [ark_pkg::NR_W-1:0] rd_nr_i, // Read key number
	output logic rd_hit_o, // Slot holds a key
	output logic [KEY_W-1:0] rd_key_o // Key in slot
);
	localparam int IDB = $clog2(N_ID);
	localparam int AW = IDB + 1 + ark_pkg::SLOT_BITS;

	if (N_ID < 2 || N_ID > 2 ** ark_pkg::ID_W || (N_ID & (N_ID - 1)) != 0 || KEY_W < 1) begin : g_bad
		$error("ark_key_bank: N_ID must be a power of two 2..256, KEY_W >= 1");
	end

	typedef struct packed {
		logic [2**AW-1:0] valid;
	} ark_bank_state_s;

	ark_bank_state_s state_reg, state_next;
	logic [KEY_W-1:0] key_mem [2**AW];
	logic [AW-1:0] wr_addr, rd_addr;

	function automatic logic [AW-1:0] slot_addr(input logic [ark_pkg::ID_W-1:0] id,
			input logic [ark_pkg::NR_W-1:0] nr);
		slot_addr = {id[IDB-1:0], nr[ark_pkg::SET_BIT], nr[ark_pkg::SLOT_BITS-1:0]};
	endfunction

	assign wr_addr = slot_addr(id_i, wr_nr_i);
	assign rd_addr = slot_addr(id_i, rd_nr_i);
	assign rd_hit_o = state_reg.valid[rd_addr];
	assign rd_key_o = key_mem[rd_addr];

	always_comb begin
		state_next = state_reg;
		if (erase_i) begin
			state_next.valid = '0;
		end else if (wr_en_i) begin
			state_next.valid[wr_addr] = 1'b1;
		end
	end

	// No reset: slots model non-volatile storage and survive rst_i
	always_ff @(posedge clk_i) begin
		if (ce_i) begin
			state_reg <= state_next;
		end
	end

	always_ff @(posedge clk_i) begin
		if (ce_i && wr_en_i && !erase_i) begin
			key_mem[wr_addr] <= wr_data_i;
		end
	end

	write_replace_a: assert property (@(posedge clk_i iff ce_i)
		wr_en_i && !erase_i |=> rd_addr != $past(wr_addr) || (rd_hit_o && rd_key_o == $past(wr_data_i)))
		else $error("written slot does not read back");
	erase_all_a: assert property (@(posedge clk_i iff ce_i) erase_i |=> state_reg.valid == '0)
		else $error("erase left a valid slot");
endmodule

// >>> ark_access_rights.sv
// What this block does
// - Proposal acceptable exactly when algorithm supported.
// - Both acceptable: accept, echoing both elements.
// - Otherwise reject with reasons, optional alternatives.
// - Auth reasons: 11 none offered, 12 unsupported.
// - Cipher reasons: 17 none offered, 18 unsupported.
// - Accepted algorithms recorded in subscription details, for identities below N_ID only.
// - Separate user-key and code sets, eight each.
// - Keys non-volatile; personal value never stored.
// - Key-type field selects user, code, user+personal.
// - Key-number top bit selects key set.
// - User+personal type addresses the user key.
// - Allocation: source code number, new key slot.
// - Cipher type selects static or derived key.
// - Separate static and derived cipher keys, eight each.
// - Static keys manual; derived keys written automatically.
// - Store flag set writes derived key, else nothing.
// - Writing a derived slot replaces its old key.
module ark_access_rights #(
	parameter int N_ID = 4,
	parameter int KEY_W = 128
) (
	input wire logic clk_i, // 40 MHz core clock
	input wire logic rst_i, // Synchronous, active high
	input wire logic ce_i, // Freezes all state when low
	input wire logic [ark_pkg::N_ALG-1:0] auth_supported_i, // Supported auth algorithms
	input wire logic [ark_pkg::N_ALG-1:0] cipher_supported_i, // Supported cipher algorithms
	input wire logic req_valid_i, // Access-rights request offered
	output logic req_ready_o, // Request taken this edge
	input wire logic [ark_pkg::ID_W-1:0] req_id_i, // Identity index of request
	input wire ark_pkg::ark_prop_s req_auth_i, // Auth proposal element
	input wire ark_pkg::ark_prop_s req_cipher_i, // Cipher proposal element
	output logic rsp_valid_o, // Answer available
	input wire logic rsp_ready_i, // Answer consumed
	output ark_pkg::ark_reply_s rsp_o, // Accept or reject answer
	input wire logic [ark_pkg::ID_W-1:0] sub_rd_id_i, // Subscription read index
	output logic sub_valid_o, // Subscription recorded
	output logic [ark_pkg::ALG_W-1:0] sub_auth_alg_o, // Recorded auth algorithm
	output logic [ark_pkg::ALG_W-1:0] sub_cipher_alg_o, // Recorded cipher algorithm
	input wire logic key_cmd_valid_i, // Key store command strobe
	input wire ark_pkg::ark_key_cmd_s key_cmd_i, // Key store command
	input wire logic [KEY_W-1:0] key_wr_data_i, // Key to write
	input wire logic key_erase_i, // Erase whole key store
	output logic key_done_o, // Command finished pulse
	output logic key_missing_o, // Key not available or refused
	output logic key_needs_personal_o, // Personal value must be supplied
	output logic [KEY_W-1:0] key_data_o // Looked-up key
);
	localparam int IDB = $clog2(N_ID);
	localparam logic [ark_pkg::ID_W:0] ID_LIM = (ark_pkg::ID_W + 1)'(N_ID);

	if (N_ID < 2 || N_ID > 2 ** ark_pkg::ID_W || (N_ID & (N_ID - 1)) != 0 || KEY_W < 1) begin : g_bad
		$error("ark_access_rights: N_ID must be a power of two 2..256, KEY_W >= 1");
	end

	typedef struct packed {
		ark_pkg::ark_neg_e fsm;
		logic [ark_pkg::ID_W-1:0] id;
		ark_pkg::ark_prop_s auth;
		ark_pkg::ark_prop_s cipher;
		ark_pkg::ark_reply_s rsp;
		logic [N_ID-1:0] sub_valid;
		logic [N_ID-1:0][ark_pkg::ALG_W-1:0] sub_auth;
		logic [N_ID-1:0][ark_pkg::ALG_W-1:0] sub_cipher;
		logic sub_rd_valid;
		logic [ark_pkg::ALG_W-1:0] sub_rd_auth;
		logic [ark_pkg::ALG_W-1:0] sub_rd_cipher;
		logic key_done;
		logic key_missing;
		logic key_personal;
		logic [KEY_W-1:0] key_data;
	} ark_state_s;

	ark_state_s state_reg, state_next;

	logic auth_ok, cipher_ok, auth_rv, cipher_rv, alt_auth_v, alt_cipher_v, rec_ok;
	logic [7:0] auth_rsn, cipher_rsn;
	logic [ark_pkg::ALG_W-1:0] alt_auth_id, alt_cipher_id;
	logic [ark_pkg::N_BANKS-1:0] bank_wr, bank_hit;
	logic [ark_pkg::N_BANKS-1:0][KEY_W-1:0] bank_key;
	logic [ark_pkg::NR_W-1:0] rd_nr, wr_nr;
	logic [1:0] rd_bank;
	logic rd_known, id_ok, key_missing, key_personal, sub_rd_ok;

	ark_alg_check #(
		.NO_CODE(ark_pkg::RSN_NO_AUTH),
		.UNSUP_CODE(ark_pkg::RSN_AUTH_UNSUP)
	) u_auth_check (
		.prop_i(state_reg.auth),
		.supported_i(auth_supported_i),
		.ok_o(auth_ok),
		.reason_valid_o(auth_rv),
		.reason_o(auth_rsn),
		.alt_valid_o(alt_auth_v),
		.alt_id_o(alt_auth_id)
	);

	ark_alg_check #(
		.NO_CODE(ark_pkg::RSN_NO_CIPHER),
		.UNSUP_CODE(ark_pkg::RSN_CIPHER_UNSUP)
	) u_cipher_check (
		.prop_i(state_reg.cipher),
		.supported_i(cipher_supported_i),
		.ok_o(cipher_ok),
		.reason_valid_o(cipher_rv),
		.reason_o(cipher_rsn),
		.alt_valid_o(alt_cipher_v),
		.alt_id_o(alt_cipher_id)
	);

	// Four banks: user keys, codes, static and derived cipher keys
	for (genvar b = 0; b < ark_pkg::N_BANKS; b++) begin : g_bank
		ark_key_bank #(
			.N_ID(N_ID),
			.KEY_W(KEY_W)
		) u_bank (
			.clk_i(clk_i),
			.ce_i(ce_i),
			.erase_i(key_erase_i),
			.id_i(key_cmd_i.id),
			.wr_en_i(bank_wr[b]),
			.wr_nr_i(wr_nr),
			.wr_data_i(key_wr_data_i),
			.rd_nr_i(rd_nr),
			.rd_hit_o(bank_hit[b]),
			.rd_key_o(bank_key[b])
		);
	end

	always_comb begin
		rd_nr = key_cmd_i.key_nr;
		wr_nr = key_cmd_i.key_nr;
		id_ok = {1'b0, key_cmd_i.id} < ID_LIM;
		if (key_cmd_i.cipher_sel) begin
			rd_known = key_cmd_i.key_type == ark_pkg::CKT_STATIC || key_cmd_i.key_type == ark_pkg::CKT_DERIVED;
			rd_bank = (key_cmd_i.key_type == ark_pkg::CKT_DERIVED) ? 2'(ark_pkg::BANK_DERIVED)
				: 2'(ark_pkg::BANK_STATIC);
		end else begin
			rd_known = key_cmd_i.key_type == ark_pkg::AKT_USER || key_cmd_i.key_type == ark_pkg::AKT_CODE
				|| key_cmd_i.key_type == ark_pkg::AKT_USER_PERSONAL;
			// Combined type reaches only the user-key part
			rd_bank = (key_cmd_i.key_type == ark_pkg::AKT_CODE) ? 2'(ark_pkg::BANK_AC)
				: 2'(ark_pkg::BANK_UAK);
		end
		key_personal = key_cmd_i.op == ark_pkg::KOP_LOOKUP && !key_cmd_i.cipher_sel
			&& key_cmd_i.key_type == ark_pkg::AKT_USER_PERSONAL;
		bank_wr = '0;
		key_missing = 1'b0;
		if (key_cmd_valid_i && !key_erase_i) begin
			unique case (key_cmd_i.op)
				ark_pkg::KOP_LOOKUP: begin
					key_missing = !id_ok || !rd_known || !bank_hit[rd_bank];
				end
				ark_pkg::KOP_ENTER: begin
					// Derived keys come only from authentication
					key_missing = !id_ok || !rd_known || rd_bank == 2'(ark_pkg::BANK_DERIVED);
					if (!key_missing) begin
						bank_wr[rd_bank] = 1'b1;
					end
				end
				ark_pkg::KOP_STORE: begin
					key_missing = !id_ok;
					if (id_ok && key_cmd_i.store_derived_key_flag) begin
						bank_wr[ark_pkg::BANK_DERIVED] = 1'b1;
					end
				end
				ark_pkg::KOP_ALLOC: begin
					rd_bank = 2'(ark_pkg::BANK_AC);
					wr_nr = key_cmd_i.new_nr;
					key_missing = !id_ok || !bank_hit[ark_pkg::BANK_AC];
					if (!key_missing) begin
						bank_wr[ark_pkg::BANK_UAK] = 1'b1;
					end
				end
			endcase
		end
	end

	assign rec_ok = {1'b0, state_reg.id} < ID_LIM;
	assign sub_rd_ok = {1'b0, sub_rd_id_i} < ID_LIM;

	always_comb begin
		state_next = state_reg;
		state_next.key_done = key_cmd_valid_i;
		state_next.key_missing = key_cmd_valid_i && key_missing;
		state_next.key_personal = key_cmd_valid_i && key_personal;
		state_next.key_data = '0;
		if (key_cmd_valid_i && key_cmd_i.op == ark_pkg::KOP_LOOKUP && !key_missing) begin
			state_next.key_data = bank_key[rd_bank];
		end
		state_next.sub_rd_valid = sub_rd_ok && state_reg.sub_valid[sub_rd_id_i[IDB-1:0]];
		state_next.sub_rd_auth = state_reg.sub_auth[sub_rd_id_i[IDB-1:0]];
		state_next.sub_rd_cipher = state_reg.sub_cipher[sub_rd_id_i[IDB-1:0]];
		unique case (state_reg.fsm)
			ark_pkg::NEG_IDLE: begin
				if (req_valid_i) begin
					state_next.id = req_id_i;
					state_next.auth = req_auth_i;
					state_next.cipher = req_cipher_i;
					state_next.fsm = ark_pkg::NEG_JUDGE;
				end
			end
			ark_pkg::NEG_JUDGE: begin
				state_next.rsp = '0;
				state_next.rsp.accept = auth_ok && cipher_ok;
				state_next.rsp.auth_echo = state_reg.auth;
				state_next.rsp.cipher_echo = state_reg.cipher;
				state_next.rsp.auth_rsn_valid = auth_rv;
				state_next.rsp.auth_rsn = auth_rsn;
				state_next.rsp.cipher_rsn_valid = cipher_rv;
				state_next.rsp.cipher_rsn = cipher_rsn;
				// Alternatives only for the element that failed
				state_next.rsp.alt_auth_valid = auth_rv && alt_auth_v;
				state_next.rsp.alt_auth_id = alt_auth_id;
				state_next.rsp.alt_cipher_valid = cipher_rv && alt_cipher_v;
				state_next.rsp.alt_cipher_id = alt_cipher_id;
				if (auth_ok && cipher_ok && rec_ok) begin
					state_next.sub_valid[state_reg.id[IDB-1:0]] = 1'b1;
					state_next.sub_auth[state_reg.id[IDB-1:0]] = state_reg.auth.alg_id;
					state_next.sub_cipher[state_reg.id[IDB-1:0]] = state_reg.cipher.alg_id;
				end
				state_next.fsm = ark_pkg::NEG_ANSWER;
			end
			ark_pkg::NEG_ANSWER: begin
				if (rsp_ready_i) begin
					state_next.fsm = ark_pkg::NEG_IDLE;
				end
			end
			default: begin
				state_next.fsm = ark_pkg::NEG_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state_reg <= '0;
			state_reg.fsm <= ark_pkg::NEG_RESET;
		end else if (ce_i) begin
			state_reg <= state_next;
		end
	end

	assign req_ready_o = state_reg.fsm == ark_pkg::NEG_IDLE && ce_i;
	assign rsp_valid_o = state_reg.fsm == ark_pkg::NEG_ANSWER;
	assign rsp_o = state_reg.rsp;
	assign sub_valid_o = state_reg.sub_rd_valid;
	assign sub_auth_alg_o = state_reg.sub_rd_auth;
	assign sub_cipher_alg_o = state_reg.sub_rd_cipher;
	assign key_done_o = state_reg.key_done;
	assign key_missing_o = state_reg.key_missing;
	assign key_needs_personal_o = state_reg.key_personal;
	assign key_data_o = state_reg.key_data;

	default clocking ark_cb @(posedge clk_i iff ce_i);
	endclocking
	default disable iff (rst_i);

	sequence accept_judged_s;
		state_reg.fsm == ark_pkg::NEG_JUDGE && auth_ok && cipher_ok && rec_ok;
	endsequence

	sequence store_on_s;
		key_cmd_valid_i && !key_erase_i && key_cmd_i.op == ark_pkg::KOP_STORE
			&& key_cmd_i.store_derived_key_flag && id_ok;
	endsequence

	sequence lookup_same_derived_s;
		key_cmd_valid_i && !key_erase_i && key_cmd_i.op == ark_pkg::KOP_LOOKUP && key_cmd_i.cipher_sel
			&& key_cmd_i.key_type == ark_pkg::CKT_DERIVED && key_cmd_i.key_nr == $past(key_cmd_i.key_nr)
			&& key_cmd_i.id == $past(key_cmd_i.id);
	endsequence

	accept_supported_a: assert property (rsp_valid_o && rsp_o.accept |-> rsp_o.auth_echo.present
		&& rsp_o.cipher_echo.present && auth_supported_i[rsp_o.auth_echo.alg_id]
		&& cipher_supported_i[rsp_o.cipher_echo.alg_id])
		else $error("accept given for unsupported element");
	judge_answer_a: assert property (state_reg.fsm == ark_pkg::NEG_JUDGE |=> rsp_valid_o
		&& rsp_o.accept == $past(auth_ok && cipher_ok) && rsp_o.auth_echo == $past(state_reg.auth))
		else $error("answer does not follow judgement");
	reject_reason_a: assert property (rsp_valid_o && !rsp_o.accept
		|-> (rsp_o.auth_rsn_valid || rsp_o.cipher_rsn_valid)
		&& (!rsp_o.alt_auth_valid || auth_supported_i[rsp_o.alt_auth_id]))
		else $error("reject without reason or with bad alternative");
	auth_codes_a: assert property (rsp_valid_o && rsp_o.auth_rsn_valid
		|-> rsp_o.auth_rsn == (rsp_o.auth_echo.present ? ark_pkg::RSN_AUTH_UNSUP : ark_pkg::RSN_NO_AUTH))
		else $error("wrong authentication reject code");
	cipher_codes_a: assert property (rsp_valid_o && rsp_o.cipher_rsn_valid
		|-> rsp_o.cipher_rsn == (rsp_o.cipher_echo.present ? ark_pkg::RSN_CIPHER_UNSUP : ark_pkg::RSN_NO_CIPHER))
		else $error("wrong cipher reject code");
	answer_hold_a: assert property (rsp_valid_o && !rsp_ready_i |=> rsp_valid_o && $stable(rsp_o))
		else $error("answer dropped before consumed");
	record_sub_a: assert property (accept_judged_s |=> state_reg.sub_valid[$past(state_reg.id[IDB-1:0])]
		&& state_reg.sub_auth[$past(state_reg.id[IDB-1:0])] == $past(state_reg.auth.alg_id))
		else $error("accepted algorithm not recorded");
	derived_store_a: assert property (store_on_s ##1 lookup_same_derived_s
		|=> key_done_o && !key_missing_o && key_data_o == $past(key_wr_data_i, 2))
		else $error("stored derived key not read back");
	store_off_a: assert property (key_cmd_valid_i && key_cmd_i.op == ark_pkg::KOP_STORE
		&& !key_cmd_i.store_derived_key_flag |-> bank_wr == '0)
		else $error("derived key written with store flag clear");
	personal_a: assert property (key_cmd_valid_i && key_personal |-> rd_bank == 2'(ark_pkg::BANK_UAK)
		##1 key_needs_personal_o)
		else $error("combined key type not routed to user key");
	unknown_type_a: assert property (key_cmd_valid_i && key_cmd_i.op == ark_pkg::KOP_LOOKUP && !rd_known
		&& !key_erase_i |=> key_missing_o && key_data_o == '0)
		else $error("unknown key type not reported missing");
endmodule

// >>> ark_pt_model.sv
module ark_pt_model (
	input wire logic clk_i, // Core clock
	input wire logic req_ready_i, // Fixed side takes request
	output logic req_valid_o, // Request offered
	output logic [ark_pkg::ID_W-1:0] req_id_o, // Identity index
	output ark_pkg::ark_prop_s req_auth_o, // Auth proposal element
	output ark_pkg::ark_prop_s req_cipher_o // Cipher proposal element
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		req_valid_o = 1'b0;
		req_id_o = '0;
		req_auth_o = '0;
		req_cipher_o = '0;
	end
	// Held until taken; afterwards the proposal lines carry inverted scrap, while the id line keeps its stale value
	task automatic send(input logic [7:0] id, input ark_pkg::ark_prop_s a, input ark_pkg::ark_prop_s c);
		@(posedge clk_i);
		#2;
		req_valid_o = 1'b1;
		req_id_o = id;
		req_auth_o = a;
		req_cipher_o = c;
		do @(posedge clk_i); while (req_ready_i !== 1'b1);
		#2;
		req_valid_o = 1'b0;
		req_auth_o = ~a;
		req_cipher_o = ~c;
	endtask
endmodule

// >>> ark_access_rights_tb.sv
module ark_access_rights_tb;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [1:0] LK = ark_pkg::KOP_LOOKUP;
	localparam logic [1:0] EN = ark_pkg::KOP_ENTER;
	localparam logic [1:0] ST = ark_pkg::KOP_STORE;
	localparam logic [1:0] AL = ark_pkg::KOP_ALLOC;
	logic clk_i, rst_i, ce_i, req_valid_i, req_ready_o, rsp_valid_o, rsp_ready_i, sub_valid_o;
	logic key_cmd_valid_i, key_erase_i, key_done_o, key_missing_o, key_needs_personal_o;
	logic [255:0] as, cs;
	logic [7:0] req_id_i, sub_rd_id_i, sub_auth_alg_o, sub_cipher_alg_o, aa, ca;
	ark_pkg::ark_prop_s req_auth_i, req_cipher_i, pa, pc;
	ark_pkg::ark_reply_s rsp_o;
	ark_pkg::ark_key_cmd_s key_cmd_i;
	logic [15:0] key_wr_data_i, key_data_o;
	logic [15:0] d [6];
	ark_pkg::ark_reply_s rq[$];
	logic [17:0] kq[$];
	int err_total = 0;
	int checked = 0;
	int i, k;
	ark_access_rights #(.N_ID(4), .KEY_W(16)) uut (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i),
		.auth_supported_i(as), .cipher_supported_i(cs), .req_valid_i(req_valid_i),
		.req_ready_o(req_ready_o), .req_id_i(req_id_i), .req_auth_i(req_auth_i), .req_cipher_i(req_cipher_i),
		.rsp_valid_o(rsp_valid_o), .rsp_ready_i(rsp_ready_i), .rsp_o(rsp_o), .sub_rd_id_i(sub_rd_id_i),
		.sub_valid_o(sub_valid_o), .sub_auth_alg_o(sub_auth_alg_o), .sub_cipher_alg_o(sub_cipher_alg_o),
		.key_cmd_valid_i(key_cmd_valid_i), .key_cmd_i(key_cmd_i), .key_wr_data_i(key_wr_data_i),
		.key_erase_i(key_erase_i), .key_done_o(key_done_o), .key_missing_o(key_missing_o),
		.key_needs_personal_o(key_needs_personal_o), .key_data_o(key_data_o));
	ark_pt_model pt (.clk_i(clk_i), .req_ready_i(req_ready_o), .req_valid_o(req_valid_i), .req_id_o(req_id_i),
		.req_auth_o(req_auth_i), .req_cipher_o(req_cipher_i));
	task automatic test_done;
		$display("checked=%0d err_total=%0d", checked, err_total);
		if (err_total == 0 && checked > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	task automatic chk_val(input string n, input logic [31:0] e, input logic [31:0] g);
		checked++;
		if (g !== e) begin
			err_total++;
			$display("[FAIL] %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic chk_rep(input ark_pkg::ark_reply_s e, input ark_pkg::ark_reply_s g);
		checked++;
		if (g !== e) begin
			err_total++;
			$display("[FAIL] reply expected %h seen %h", e, g);
		end
	endtask
	function automatic logic [7:0] pick(input logic [255:0] m, input logic want);
		logic [7:0] v;
		v = 8'($urandom);
		while (m[v] !== want)
			v = v + 8'h01;
		return v;
	endfunction
	function automatic logic [7:0] low(input logic [255:0] m);
		logic [7:0] v;
		v = 8'h00;
		for (int j = 255; j >= 0; j--)
			if (m[j])
				v = 8'(j);
		return v;
	endfunction
	function automatic ark_pkg::ark_reply_s er(input ark_pkg::ark_prop_s a, input ark_pkg::ark_prop_s c);
		ark_pkg::ark_reply_s r;
		logic ao, co;
		ao = a.present && as[a.alg_id];
		co = c.present && cs[c.alg_id];
		r = '0;
		r.accept = ao && co;
		r.auth_rsn_valid = !ao;
		r.auth_rsn = ao ? 8'h00 : (a.present ? ark_pkg::RSN_AUTH_UNSUP : ark_pkg::RSN_NO_AUTH);
		r.cipher_rsn_valid = !co;
		r.cipher_rsn = co ? 8'h00 : (c.present ? ark_pkg::RSN_CIPHER_UNSUP : ark_pkg::RSN_NO_CIPHER);
		r.auth_echo = a;
		r.cipher_echo = c;
		// Alternative id always shows the preferred one; valid only on a failed element
		r.alt_auth_valid = !ao && (as != '0);
		r.alt_auth_id = low(as);
		r.alt_cipher_valid = !co && (cs != '0);
		r.alt_cipher_id = low(cs);
		return r;
	endfunction
	// Mode 0 supported, 1 not offered, 2 unsupported
	function automatic ark_pkg::ark_prop_s mk(input logic [255:0] m, input int mode);
		ark_pkg::ark_prop_s p;
		p = $bits(p)'($urandom);
		p.present = (mode != 1);
		p.alg_id = pick(m, mode == 0);
		return p;
	endfunction
	task automatic kc(input logic [1:0] op, input logic s, input logic [3:0] ty, input logic [3:0] nr,
		input logic [3:0] nn, input logic fl, input logic [7:0] id, input logic [15:0] dv, input logic [17:0] ex);
		@(posedge clk_i);
		#2;
		key_cmd_valid_i = 1'b1;
		key_cmd_i = '{op: op, cipher_sel: s, key_type: ty, key_nr: nr, new_nr: nn, store_derived_key_flag: fl, id: id};
		key_wr_data_i = dv;
		kq.push_back(ex);
	endtask
	initial begin
		clk_i = 1'b0;
		forever #12.5 clk_i = ~clk_i;
	end
	initial begin
		rsp_ready_i = 1'b0;
		forever begin
			@(posedge clk_i);
			#2;
			rsp_ready_i = 1'($urandom);
		end
	end
	always @(negedge clk_i) begin
		if (rsp_valid_o === 1'b1 && rsp_ready_i === 1'b1)
			chk_rep(rq.size() > 0 ? rq.pop_front() : '1, rsp_o);
		if (key_done_o === 1'b1)
			chk_val("key", kq.size() > 0 ? kq.pop_front() : '1, {key_missing_o, key_needs_personal_o, key_data_o});
	end
	initial begin
		#(25 * 4000);
		err_total++;
		$display("[FAIL] watchdog expected done seen hang");
		test_done();
	end
	initial begin
		k = $urandom(80);
		rst_i = 1'b1;
		ce_i = 1'b1;
		sub_rd_id_i = 8'h00;
		key_cmd_valid_i = 1'b0;
		key_cmd_i = '0;
		key_wr_data_i = '0;
		key_erase_i = 1'b0;
		for (i = 0; i < 8; i++) begin
			as[i*32+:32] = $urandom;
			cs[i*32+:32] = $urandom;
		end
		for (i = 0; i < 6; i++)
			d[i] = 16'($urandom);
		repeat (20) @(posedge clk_i);
		#2;
		rst_i = 1'b0;
		key_erase_i = 1'b1;
		@(posedge clk_i);
		#2;
		key_erase_i = 1'b0;
		for (k = 0; k < 9; k++) begin
			pa = mk(as, k % 3);
			pc = mk(cs, k / 3);
			if (k == 0) begin
				aa = pa.alg_id;
				ca = pc.alg_id;
			end
			rq.push_back(er(pa, pc));
			pt.send(8'(k % 4), pa, pc);
		end
		for (i = 0; i < 60 && rq.size() > 0; i++)
			@(posedge clk_i);
		#2;
		for (k = 0; k < 4; k += 3) begin
			sub_rd_id_i = 8'(k);
			@(posedge clk_i);
			#2;
			chk_val("sub", k == 0 ? {15'h0, 1'b1, aa, ca} : 32'h0, {sub_valid_o, sub_auth_alg_o, sub_cipher_alg_o});
		end
		kc(ST, 1, 2, 1, 0, 1, 1, d[0], 18'h0);
		kc(LK, 1, 2, 1, 0, 0, 1, 0, {2'b00, d[0]});
		kc(ST, 1, 2, 2, 0, 0, 1, d[1], 18'h0);
		kc(LK, 1, 2, 2, 0, 0, 1, 0, 18'h20000);
		kc(ST, 1, 2, 1, 0, 1, 1, d[2], 18'h0);
		kc(LK, 1, 2, 1, 0, 0, 1, 0, {2'b00, d[2]});
		kc(EN, 0, 1, 9, 0, 0, 1, d[3], 18'h0);
		kc(LK, 0, 1, 1, 0, 0, 1, 0, 18'h20000);
		kc(LK, 0, 3, 9, 0, 0, 1, 0, {2'b01, d[3]});
		kc(LK, 1, 1, 9, 0, 0, 1, 0, 18'h20000);
		kc(AL, 0, 2, 2, 5, 0, 1, d[4], 18'h20000);
		kc(EN, 0, 2, 2, 0, 0, 1, d[5], 18'h0);
		kc(AL, 0, 2, 2, 5, 0, 1, d[4], 18'h0);
		kc(LK, 0, 1, 5, 0, 0, 1, 0, {2'b00, d[4]});
		kc(LK, 0, 2, 2, 0, 0, 1, 0, {2'b00, d[5]});
		kc(EN, 1, 2, 3, 0, 0, 1, d[1], 18'h20000);
		kc(LK, 1, 2, 1, 0, 0, 2, 0, 18'h20000);
		kc(LK, 0, 1, 9, 0, 0, 4, 0, 18'h20000);
		kc(LK, 1, 3, 1, 0, 0, 1, 0, 18'h20000);
		@(posedge clk_i);
		#2;
		key_cmd_valid_i = 1'b0;
		repeat (3) @(posedge clk_i);
		#2;
		// Enable low: a held command must not be taken, ready must drop
		ce_i = 1'b0;
		key_cmd_valid_i = 1'b1;
		repeat (3) @(posedge clk_i);
		#2;
		chk_val("frozen", 32'h0, {key_done_o, req_ready_o});
		key_cmd_valid_i = 1'b0;
		ce_i = 1'b1;
		@(posedge clk_i);
		#2;
		chk_val("ready", 32'h1, {key_done_o, req_ready_o});
		chk_val("pending", 32'h0, 32'(rq.size() + kq.size()));
		test_done();
	end
endmodule
